// ### mmp_pkg.sv
/*
 * Shared constants, carrier structs, state structs and state enums of the
 * MAC-side MII and station management port.
 * Assumes MCLK at 10 MHz; TX_CLK and RX_CLK come from the PHY.
 */
// How it works
// [R1] MDC is divided down from MCLK to at most 1.5 MHz.
// [R2] MDIO changes after MDC falls and is sampled when MDC rises.
// [R3] management frames: preamble, start, opcode, addresses, turnaround, 16 data bits.
// [R4] receive nibble, RX_DV and RX_ER are registered on RX_CLK only.
// [R5] the PHY drives RXD and RX_DV on RX_CLK; RX_DV marks frame data.
// [R6] the PHY raises RX_ER on RX_CLK for receive errors.
// [R7] the PHY holds COL high during a collision.
// [R8] the PHY raises CRS asynchronously while either medium is busy.
// [R9] TXD, TX_EN and TX_ER come from TX_CLK flip-flops.
// [R10] TXD changes only on rising TX_CLK edges.
// [R11] TX_EN is high exactly over the frame's nibbles, on TX_CLK edges; the code also holds it high, with TX_ER set, through underrun gaps.
// [R12] TX_ER held during a frame makes the PHY corrupt that frame.
// [R13] CRS and COL pass two flip-flops before use.
`default_nettype none
package mmp_pkg;
    localparam int unsigned MCLK_FREQ_KHZ = 10000;
    localparam int unsigned MDC_FREQ_KHZ = 1500;
    // half period rounds up so MDC never exceeds its maximum rate
    localparam int unsigned MDC_HALF_CYC =
        (MCLK_FREQ_KHZ + 2 * MDC_FREQ_KHZ - 1) / (2 * MDC_FREQ_KHZ);
    localparam int unsigned MDC_DIV_W = 3;
    localparam logic [MDC_DIV_W-1:0] MDC_DIV_LAST = MDC_DIV_W'(MDC_HALF_CYC - 1);

    localparam logic [31:0] MF_PREAMBLE = 32'hFFFFFFFF;
    localparam logic [1:0] MF_START = 2'h1;
    localparam logic [1:0] MF_OP_READ = 2'h2;
    localparam logic [1:0] MF_OP_WRITE = 2'h1;
    localparam logic [1:0] MF_TA_WRITE = 2'h2;
    localparam logic [5:0] MF_LAST_BIT = 6'h3F;
    localparam logic [5:0] MF_RD_DRIVE_LAST = 6'h2D;
    localparam logic [5:0] MF_RD_DATA_FIRST = 6'h30;

    typedef enum logic [1:0] {MG_IDLE = 2'b01, MG_RUN = 2'b10} mmp_mg_e;
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} mmp_tx_e;

    typedef struct packed {
        logic wr;
        logic [4:0] phy;
        logic [4:0] regad;
        logic [15:0] wdata;
    } mmp_mgmt_cmd_s;

    typedef struct packed {
        logic [3:0] data;
        logic err;
        logic last;
    } mmp_tx_nib_s;

    typedef struct packed {
        logic [7:0] data;
        logic eof;
        logic err;
        logic ovr;
    } mmp_rx_word_s;

    typedef struct packed {
        logic [MDC_DIV_W-1:0] div;
        logic mdc;
    } mmp_mdc_s;

    typedef struct packed {
        mmp_mg_e st;
        logic busy;
        logic [63:0] frame;
        logic [5:0] bit_idx;
        logic rd;
        logic [15:0] rdata;
        logic done;
        logic mdio_o;
        logic mdio_oe;
        mmp_tx_nib_s tx_hold;
        logic tx_req_t;
        logic tx_ready;
        logic rx_seen_t;
        logic rx_valid;
        mmp_rx_word_s rx_word;
        logic crs;
        logic col;
        logic irq;
    } mmp_mg_s;

    typedef struct packed {
        mmp_tx_e st;
        logic seen_t;
        logic [3:0] txd;
        logic en;
        logic er;
    } mmp_tx_s;

    typedef struct packed {
        logic [3:0] d;
        logic dv;
        logic er;
        logic dv_prev;
        logic [3:0] lo;
        logic half;
        logic err;
        logic ovr;
        mmp_rx_word_s word;
        logic req_t;
    } mmp_rx_s;

    localparam mmp_mdc_s MDC_RST = '{default: '0};
    localparam mmp_mg_s MG_RST = '{st: MG_IDLE, tx_ready: 1'b1, mdio_o: 1'b1, default: '0};
    localparam mmp_tx_s TX_RST = '{st: TX_IDLE, default: '0};
    localparam mmp_rx_s RX_RST = '{default: '0};
endpackage
`default_nettype wire

// ### mmp_sync.sv
/*
 * Two-flop synchroniser for a vector of independent levels or toggles.
 * Assumes each bit may change at any time relative to clk.
 */
`timescale 1ns/1ns
`default_nettype none
module mmp_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [1:0][W-1:0] st_q;
    logic [1:0][W-1:0] st_d;

    always_comb
    begin
        st_d[0] = d;
        st_d[1] = st_q[0];
    end

    // no reset: the stages must keep tracking while the block is held
    always_ff @(posedge clk)
    begin
        st_q <= st_d;
    end

    assign q = st_q[1];
endmodule
`default_nettype wire

// ### mmp_mdcgen.sv
/*
 * Management clock divider: MDC level plus rise and fall strobes.
 * Assumes run is a registered level from the management sequencer.
 */
`timescale 1ns/1ns
`default_nettype none
module mmp_mdcgen
    import mmp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic run,
    output logic mdc,
    output logic rise,
    output logic fall
);
    mmp_mdc_s s_q;
    mmp_mdc_s s_d;
    logic tick;

    assign tick = run && (s_q.div == MDC_DIV_LAST);

    always_comb
    begin
        s_d = s_q;
        if (!run)
        begin
            s_d = MDC_RST;
        end
        // [R1] half period count
        else if (tick)
        begin
            s_d.div = '0;
            s_d.mdc = ~s_q.mdc;
        end
        else
        begin
            s_d.div = s_q.div + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q <= MDC_RST;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign mdc = s_q.mdc;
    assign rise = tick && !s_q.mdc;
    assign fall = tick && s_q.mdc;
endmodule
`default_nettype wire

// ### mmp_top.sv
/*
 * MAC-side MII port with station management master.
 * Management, user handshakes and CRS/COL/interrupt sync run on MCLK;
 * transmit pins run on TX_CLK and receive sampling on RX_CLK, both
 * supplied by the PHY. Words cross domains by toggle handshakes.
 * Assumes MDIO is open-drain style with a pull-up outside.
 */
`timescale 1ns/1ns
`default_nettype none
module mmp_top
    import mmp_pkg::*;
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic MGMT_REQ,
    input wire mmp_mgmt_cmd_s MGMT_CMD,
    output logic MGMT_BUSY,
    output logic MGMT_DONE,
    output logic [15:0] MGMT_RDATA,
    output logic MDC,
    input wire logic MDIO_I,
    output logic MDIO_O,
    output logic MDIO_OE,
    input wire logic PHY_MGMT_IRQ_IN,
    output logic PHY_IRQ,
    input wire logic CRS,
    input wire logic COL,
    output logic CARRIER,
    output logic COLLISION,
    input wire logic TX_VALID,
    input wire mmp_tx_nib_s TX_NIB,
    output logic TX_READY,
    input wire logic TX_CLK,
    output logic [3:0] TXD,
    output logic TX_EN,
    output logic TX_ER,
    input wire logic RX_CLK,
    input wire logic [3:0] RXD,
    input wire logic RX_DV,
    input wire logic RX_ER,
    output logic RX_VALID,
    output mmp_rx_word_s RX_WORD
);
    mmp_mg_s mg_q;
    mmp_mg_s mg_d;
    mmp_tx_s tx_q;
    mmp_tx_s tx_d;
    mmp_rx_s rx_q;
    mmp_rx_s rx_d;

    logic mdc_rise;
    logic mdc_fall;
    logic ms_mdio;
    logic ms_crs;
    logic ms_col;
    logic ms_irq;
    logic ms_tx_ack;
    logic ms_rx_req;
    logic ts_rst;
    logic ts_ce;
    logic ts_req;
    logic rs_rst;
    logic rs_ce;
    logic rs_ack;
    logic emit;
    mmp_rx_word_s ew;

    // ---------------- MCLK domain ----------------

    // [R13] two-stage sync of CRS and COL
    mmp_sync #(
        .W(6)
    ) u_sync_m (
        .clk(MCLK),
        .d({MDIO_I, CRS, COL, PHY_MGMT_IRQ_IN, tx_q.seen_t, rx_q.req_t}),
        .q({ms_mdio, ms_crs, ms_col, ms_irq, ms_tx_ack, ms_rx_req})
    );

    mmp_mdcgen u_mdc (
        .clk(MCLK),
        .rst(SRST),
        .ce(CE),
        .run(mg_q.busy),
        .mdc(MDC),
        .rise(mdc_rise),
        .fall(mdc_fall)
    );

    always_comb
    begin
        mg_d = mg_q;
        mg_d.done = 1'b0;
        mg_d.rx_valid = 1'b0;
        // [R13] synced levels only
        mg_d.crs = ms_crs;
        mg_d.col = ms_col;
        mg_d.irq = ms_irq;

        case (mg_q.st)
            MG_IDLE:
            begin
                // [R3] build the whole frame up front
                if (MGMT_REQ)
                begin
                    mg_d.st = MG_RUN;
                    mg_d.busy = 1'b1;
                    mg_d.rd = !MGMT_CMD.wr;
                    mg_d.bit_idx = '0;
                    mg_d.frame = {MF_PREAMBLE, MF_START,
                                  MGMT_CMD.wr ? MF_OP_WRITE : MF_OP_READ,
                                  MGMT_CMD.phy, MGMT_CMD.regad,
                                  MGMT_CMD.wr ? MF_TA_WRITE : 2'h0,
                                  MGMT_CMD.wr ? MGMT_CMD.wdata : 16'h0000};
                    mg_d.mdio_o = 1'b1;
                    mg_d.mdio_oe = 1'b1;
                end
            end
            MG_RUN:
            begin
                // [R2] sample read data at the rising MDC edge
                if (mdc_rise && mg_q.rd && (mg_q.bit_idx >= MF_RD_DATA_FIRST))
                begin
                    mg_d.rdata = {mg_q.rdata[14:0], ms_mdio};
                end
                // [R2] drive the next bit after MDC falls
                if (mdc_fall)
                begin
                    if (mg_q.bit_idx == MF_LAST_BIT)
                    begin
                        mg_d.st = MG_IDLE;
                        mg_d.busy = 1'b0;
                        mg_d.done = 1'b1;
                        mg_d.mdio_o = 1'b1;
                        mg_d.mdio_oe = 1'b0;
                    end
                    else
                    begin
                        mg_d.bit_idx = mg_q.bit_idx + 1'b1;
                        mg_d.frame = {mg_q.frame[62:0], 1'b0};
                        mg_d.mdio_o = mg_q.frame[62];
                        // [R3] release the line from turnaround on reads
                        mg_d.mdio_oe = !mg_q.rd || (mg_q.bit_idx < MF_RD_DRIVE_LAST);
                    end
                end
            end
            default:
            begin
                mg_d = MG_RST;
            end
        endcase

        // transmit nibble hand-off; hold stays put until the ack returns
        if (mg_q.tx_ready && TX_VALID)
        begin
            mg_d.tx_hold = TX_NIB;
            mg_d.tx_req_t = ~mg_q.tx_req_t;
            mg_d.tx_ready = 1'b0;
        end
        else if (!mg_q.tx_ready && (ms_tx_ack == mg_q.tx_req_t))
        begin
            mg_d.tx_ready = 1'b1;
        end

        // receive word take-over; seen toggle doubles as the ack
        if (ms_rx_req != mg_q.rx_seen_t)
        begin
            mg_d.rx_seen_t = ms_rx_req;
            mg_d.rx_valid = 1'b1;
            mg_d.rx_word = rx_q.word;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            mg_q <= MG_RST;
        end
        else if (CE)
        begin
            mg_q <= mg_d;
        end
    end

    assign MGMT_BUSY = mg_q.busy;
    assign MGMT_DONE = mg_q.done;
    assign MGMT_RDATA = mg_q.rdata;
    assign MDIO_O = mg_q.mdio_o;
    assign MDIO_OE = mg_q.mdio_oe;
    assign PHY_IRQ = mg_q.irq;
    assign CARRIER = mg_q.crs;
    assign COLLISION = mg_q.col;
    assign TX_READY = mg_q.tx_ready;
    assign RX_VALID = mg_q.rx_valid;
    assign RX_WORD = mg_q.rx_word;

    // ---------------- TX_CLK domain ----------------

    mmp_sync #(
        .W(3)
    ) u_sync_t (
        .clk(TX_CLK),
        .d({SRST, CE, mg_q.tx_req_t}),
        .q({ts_rst, ts_ce, ts_req})
    );

    always_comb
    begin
        tx_d = tx_q;
        case (tx_q.st)
            TX_IDLE:
            begin
                tx_d.txd = 4'h0;
                tx_d.en = 1'b0;
                tx_d.er = 1'b0;
            end
            TX_SEND:
            begin
                // [R12] underrun inside a frame poisons it
                tx_d.en = 1'b1;
                tx_d.er = 1'b1;
            end
            default:
            begin
                tx_d = TX_RST;
            end
        endcase
        // [R11] enable follows each fresh nibble
        if (ts_req != tx_q.seen_t)
        begin
            tx_d.seen_t = ts_req;
            tx_d.txd = mg_q.tx_hold.data;
            tx_d.en = 1'b1;
            tx_d.er = mg_q.tx_hold.err;
            tx_d.st = mg_q.tx_hold.last ? TX_IDLE : TX_SEND;
        end
    end

    // [R9] [R10] all transmit pins from TX_CLK flops
    always_ff @(posedge TX_CLK)
    begin
        if (ts_rst)
        begin
            tx_q <= TX_RST;
        end
        else if (ts_ce)
        begin
            tx_q <= tx_d;
        end
    end

    assign TXD = tx_q.txd;
    assign TX_EN = tx_q.en;
    assign TX_ER = tx_q.er;

    // ---------------- RX_CLK domain ----------------

    mmp_sync #(
        .W(3)
    ) u_sync_r (
        .clk(RX_CLK),
        .d({SRST, CE, mg_q.rx_seen_t}),
        .q({rs_rst, rs_ce, rs_ack})
    );

    always_comb
    begin
        rx_d = rx_q;
        emit = 1'b0;
        ew = '0;
        // [R4] pins registered on RX_CLK, no sync needed
        rx_d.d = RXD;
        rx_d.dv = RX_DV;
        rx_d.er = RX_ER;
        rx_d.dv_prev = rx_q.dv;
        if (rx_q.dv)
        begin
            if (rx_q.er)
            begin
                rx_d.err = 1'b1;
            end
            // low nibble first
            if (!rx_q.half)
            begin
                rx_d.lo = rx_q.d;
                rx_d.half = 1'b1;
            end
            else
            begin
                emit = 1'b1;
                ew.data = {rx_q.d, rx_q.lo};
                ew.err = rx_q.err | rx_q.er;
                rx_d.half = 1'b0;
            end
        end
        else if (rx_q.dv_prev)
        begin
            // end marker; an odd nibble counts as an error
            emit = 1'b1;
            ew.eof = 1'b1;
            ew.err = rx_q.err | rx_q.half;
            ew.ovr = rx_q.ovr;
            rx_d.err = 1'b0;
            rx_d.ovr = 1'b0;
            rx_d.half = 1'b0;
        end
        // no buffering: a word arriving while the last is unacked is dropped
        if (emit)
        begin
            if (rs_ack != rx_q.req_t)
            begin
                if (!ew.eof)
                begin
                    rx_d.ovr = 1'b1;
                end
            end
            else
            begin
                rx_d.word = ew;
                rx_d.req_t = ~rx_q.req_t;
            end
        end
    end

    always_ff @(posedge RX_CLK)
    begin
        if (rs_rst)
        begin
            rx_q <= RX_RST;
        end
        else if (rs_ce)
        begin
            rx_q <= rx_d;
        end
    end
endmodule
`default_nettype wire

// ### mmp_top_props.sv
/* Timing checker for mmp_top, bound to its ports.
   Assumes CE stays high and SRST resets every clock domain. */
`timescale 1ns/1ns
`default_nettype none
module mmp_top_props
    import mmp_pkg::*;
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic MGMT_REQ,
    input wire logic MGMT_BUSY,
    input wire logic MGMT_DONE,
    input wire logic MDC,
    input wire logic MDIO_O,
    input wire logic MDIO_OE,
    input wire logic CRS,
    input wire logic COL,
    input wire logic CARRIER,
    input wire logic COLLISION,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic TX_CLK,
    input wire logic TX_EN,
    input wire logic TX_ER,
    input wire logic RX_VALID
);
    logic [9:0] busy_cnt_q;
    always_ff @(posedge MCLK)
    begin
        busy_cnt_q <= (SRST || !MGMT_BUSY) ? 10'h000 : busy_cnt_q + 10'h001;
    end
    chk_req_start: assert property (@(posedge MCLK) disable iff (SRST)
        CE && MGMT_REQ && !MGMT_BUSY |=> MGMT_BUSY && MDIO_OE && MDIO_O)
        else $error("frame did not start");
    chk_frame_len: assert property (@(posedge MCLK) disable iff (SRST)
        MGMT_DONE |-> busy_cnt_q == 10'h200 && !MGMT_BUSY && !MDIO_OE)
        else $error("frame length wrong");
    chk_mdc_idle: assert property (@(posedge MCLK) disable iff (SRST)
        !MGMT_BUSY |-> !MDC) else $error("clock runs while idle");
    chk_mdc_half: assert property (@(posedge MCLK) disable iff (SRST)
        $rose(MDC) |-> MDC[*4] ##1 !MDC[*4]) else $error("clock half period");
    chk_mdio_edge: assert property (@(posedge MCLK) disable iff (SRST)
        MDIO_OE && $past(MDIO_OE) && $changed(MDIO_O) |-> $fell(MDC))
        else $error("data moved off clock fall");
    chk_tx_take: assert property (@(posedge MCLK) disable iff (SRST)
        CE && TX_VALID && TX_READY |=> !TX_READY) else $error("nibble not taken");
    chk_tx_err_frame: assert property (@(posedge TX_CLK) disable iff (SRST)
        TX_ER |-> TX_EN) else $error("coding error outside frame");
    chk_crs_sync: assert property (@(posedge MCLK) disable iff (SRST)
        $rose(CRS) |-> ##3 CARRIER) else $error("carrier late");
    chk_col_sync: assert property (@(posedge MCLK) disable iff (SRST)
        $rose(COL) |-> ##3 COLLISION) else $error("collision late");
    chk_rx_pulse: assert property (@(posedge MCLK) disable iff (SRST)
        RX_VALID |=> !RX_VALID) else $error("receive strobe too long");
    cover property (@(posedge MCLK) MGMT_DONE);
    cover property (@(posedge MCLK) RX_VALID);
    cover property (@(posedge TX_CLK) $rose(TX_EN));
endmodule
bind mmp_top mmp_top_props mmp_top_props_i (.MCLK, .SRST, .CE, .MGMT_REQ, .MGMT_BUSY,
    .MGMT_DONE, .MDC, .MDIO_O, .MDIO_OE, .CRS, .COL, .CARRIER, .COLLISION, .TX_VALID,
    .TX_READY, .TX_CLK, .TX_EN, .TX_ER, .RX_VALID);
`default_nettype wire

// ### mmp_phy_model.sv
/* Behavioural PHY: management responder, nibble receiver and sender.
   Assumes a pull-up on MDIO; MII clocks run continuously, as a PHY's do. */
`timescale 1ns/1ns
`default_nettype none
module mmp_phy_model
(
    input wire logic MDC,
    input wire logic MDIO_O,
    input wire logic MDIO_OE,
    output logic MDIO_I,
    output logic PHY_MGMT_IRQ_IN,
    output logic CRS,
    output logic COL,
    output logic TX_CLK,
    input wire logic [3:0] TXD,
    input wire logic TX_EN,
    input wire logic TX_ER,
    output logic RX_CLK,
    output logic [3:0] RXD,
    output logic RX_DV,
    output logic RX_ER
);
    logic [63:0] sh = '0;
    logic [4:0] n = '0;
    logic run = 1'b0;
    logic rd = 1'b0;
    logic drv = 1'b0;
    logic dout = 1'b1;
    logic [4:0] r = '0;
    logic [4:0] last_phy = '0;
    logic [15:0] mem [32];
    logic [4:0] txq [$];
    logic en_prev = 1'b0;
    int nfr = 0;
    initial
    begin
        {TX_CLK, RX_CLK, RX_DV, RX_ER, CRS, COL, PHY_MGMT_IRQ_IN} = '0;
        RXD = 4'hF;
    end
    always #16 TX_CLK = ~TX_CLK;
    initial #7 forever #16 RX_CLK = ~RX_CLK;
    assign MDIO_I = MDIO_OE ? MDIO_O : (drv ? dout : 1'b1);
    always @(posedge MDC)
    begin
        sh = {sh[62:0], MDIO_I};
        if (run)
            n = n + 5'h01;
        if (!run && sh[33:0] == 34'h3FFFFFFFD)
            run = 1'b1;
        else if (n == 5'h0D)
        begin
            rd = sh[12:11] == 2'h2;
            last_phy = sh[10:6];
            r = sh[5:1];
            drv = rd;
            dout = 1'b0;
        end
        else if (n > 5'h0D && n < 5'h1E)
            dout = mem[r][29 - n];
        else if (n == 5'h1E)
        begin
            if (!rd)
                mem[r] = sh[15:0];
            {run, drv, n} = '0;
        end
    end
    always @(posedge TX_CLK)
    begin
        if (TX_EN)
            txq.push_back({TX_ER, TXD});
        if (TX_EN && !en_prev)
            nfr++;
        en_prev = TX_EN;
    end
    task automatic rx_byte(input logic [7:0] b, input logic er);
        @(posedge RX_CLK);
        #1;
        {RXD, RX_DV, RX_ER} = {b[3:0], 1'b1, er};
        @(posedge RX_CLK);
        #1;
        {RXD, RX_ER} = {b[7:4], 1'b0};
        @(posedge RX_CLK);
        #1;
        {RXD, RX_DV} = {~b[7:4], 1'b0};
    endtask
    task automatic sense(input logic c, input logic k, input logic i);
        {CRS, COL, PHY_MGMT_IRQ_IN} = {c, k, i};
    endtask
endmodule
`default_nettype wire

// ### mmp_top_tb.sv
/* Self-checking bench for mmp_top against the behavioural PHY.
   Assumes the PHY model makes both link clocks. */
`timescale 1ns/1ns
`default_nettype none
module mmp_top_tb;
    import mmp_pkg::*;
    logic MCLK = 1'b0;
    logic SRST = 1'b1;
    logic CE = 1'b1;
    logic MGMT_REQ = 1'b0;
    mmp_mgmt_cmd_s MGMT_CMD = '0;
    logic TX_VALID = 1'b0;
    mmp_tx_nib_s TX_NIB = '0;
    wire MGMT_BUSY, MGMT_DONE, MDC, MDIO_I, MDIO_O, MDIO_OE, PHY_MGMT_IRQ_IN, PHY_IRQ;
    wire CRS, COL, CARRIER, COLLISION, TX_READY, TX_CLK, TX_EN, TX_ER, RX_CLK, RX_DV;
    wire RX_ER, RX_VALID;
    wire [15:0] MGMT_RDATA;
    wire [3:0] TXD, RXD;
    wire mmp_rx_word_s RX_WORD;
    int n_fail = 0;
    int total_checks = 0;
    mmp_top mmp_top_i (.MCLK, .SRST, .CE, .MGMT_REQ, .MGMT_CMD, .MGMT_BUSY,
        .MGMT_DONE, .MGMT_RDATA, .MDC, .MDIO_I, .MDIO_O, .MDIO_OE, .PHY_MGMT_IRQ_IN,
        .PHY_IRQ, .CRS, .COL, .CARRIER, .COLLISION, .TX_VALID, .TX_NIB, .TX_READY,
        .TX_CLK, .TXD, .TX_EN, .TX_ER, .RX_CLK, .RXD, .RX_DV, .RX_ER, .RX_VALID, .RX_WORD);
    mmp_phy_model mmp_phy_model_i (.MDC, .MDIO_O, .MDIO_OE, .MDIO_I, .PHY_MGMT_IRQ_IN,
        .CRS, .COL, .TX_CLK, .TXD, .TX_EN, .TX_ER, .RX_CLK, .RXD, .RX_DV, .RX_ER);
    always #50 MCLK = ~MCLK;
    task automatic ck(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    task automatic results;
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic mgmt(input logic wr, input logic [4:0] r, input logic [15:0] d);
        @(posedge MCLK);
        #1;
        MGMT_REQ = 1'b1;
        MGMT_CMD = '{wr: wr, phy: 5'h0B, regad: r, wdata: d};
        @(posedge MCLK);
        #1;
        MGMT_REQ = 1'b0;
        for (int i = 0; i < 600 && MGMT_DONE !== 1'b1; i++)
        begin
            @(posedge MCLK);
            #1;
        end
        ck(MGMT_DONE === 1'b1, "frame end");
    endtask
    task automatic mgmt_rw;
        mgmt(1'b1, 5'h1F, 16'hA5C3);
        ck(mmp_phy_model_i.mem[31] === 16'hA5C3, "write data");
        ck(mmp_phy_model_i.last_phy === 5'h0B, "phy address");
        mgmt(1'b0, 5'h1F, 16'h0000);
        ck(MGMT_RDATA === 16'hA5C3, "read data");
    endtask
    task automatic tx_nib(input mmp_tx_nib_s v);
        @(posedge MCLK);
        #1;
        TX_VALID = 1'b1;
        TX_NIB = v;
        // ready looked at once settled; the following edge takes the nibble
        for (int i = 0; i < 60 && TX_READY !== 1'b1; i++)
        begin
            @(posedge MCLK);
            #1;
        end
        ck(TX_READY === 1'b1, "ready never back");
        @(posedge MCLK);
        #1;
        TX_VALID = 1'b0;
    endtask
    task automatic tx_frame(input logic [3:0] a, input logic e, input logic two);
        int f;
        f = mmp_phy_model_i.nfr;
        mmp_phy_model_i.txq.delete();
        tx_nib('{data: a, err: e, last: !two});
        if (two)
            tx_nib('{data: 4'hC, err: 1'b0, last: 1'b1});
        repeat (20) @(posedge MCLK);
        ck(mmp_phy_model_i.txq[0] === {e, a}, "first nibble");
        ck(mmp_phy_model_i.txq[$] === (two ? 5'h0C : {e, a}), "last nibble");
        ck(mmp_phy_model_i.nfr == f + 1, "enable run count");
    endtask
    task automatic rx_wait;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge MCLK);
            #1;
            if (RX_VALID === 1'b1)
                break;
        end
        ck(RX_VALID === 1'b1, "no receive word");
    endtask
    task automatic rx_words;
        mmp_phy_model_i.rx_byte(8'h5A, 1'b0);
        rx_wait();
        ck(RX_WORD === mmp_rx_word_s'{data: 8'h5A, default: '0}, "receive byte");
        repeat (10) @(posedge MCLK);
        mmp_phy_model_i.rx_byte(8'hC3, 1'b1);
        rx_wait();
        ck(RX_WORD.data === 8'hC3 && RX_WORD.err === 1'b1, "receive error");
    endtask
    task automatic sense_pins;
        mmp_phy_model_i.sense(1'b1, 1'b1, 1'b1);
        repeat (5) @(posedge MCLK);
        #1;
        ck(CARRIER === 1'b1 && COLLISION === 1'b1 && PHY_IRQ === 1'b1, "sense high");
        mmp_phy_model_i.sense(1'b0, 1'b0, 1'b0);
        repeat (5) @(posedge MCLK);
        #1;
        ck(CARRIER === 1'b0 && COLLISION === 1'b0 && PHY_IRQ === 1'b0, "sense low");
    endtask
    task automatic ce_hold;
        @(posedge MCLK);
        #1;
        CE = 1'b0;
        MGMT_REQ = 1'b1;
        repeat (4) @(posedge MCLK);
        #1;
        ck(MGMT_BUSY === 1'b0, "frame started while frozen");
        MGMT_REQ = 1'b0;
        CE = 1'b1;
        repeat (4) @(posedge MCLK);
        #1;
        ck(MGMT_BUSY === 1'b0 && MDC === 1'b0, "stale request taken");
    endtask
    initial
    begin
        // two cycles still span several edges of each link clock
        repeat (2) @(posedge MCLK);
        #1;
        SRST = 1'b0;
        mgmt_rw();
        ce_hold();
        tx_frame(4'h9, 1'b0, 1'b0);
        tx_frame(4'h6, 1'b1, 1'b0);
        tx_frame(4'h3, 1'b0, 1'b1);
        rx_words();
        sense_pins();
        results();
    end
    initial
    begin
        #400000;
        n_fail++;
        results();
    end
endmodule
`default_nettype wire
